/* hdl/nacs_defs.svh */
// Notes on behaviour
// - Add immediate to accumulator; carry unchanged.
// - Immediate add overflow skips next instruction.
// - Start clears done flag; converts or compares.
// - Mode select is control register bit three.
// - Add memory nibble to accumulator.
// - Add memory and carry; load carry out.
// - Add memory without carry keeps carry.
`ifndef NACS_DEFS_SVH
`define NACS_DEFS_SVH
`define NACS_DATA_W        4
`define NACS_MODE_BIT      3
`define NACS_ACC_RESET     4'h0
`define NACS_CARRY_RESET   1'b0
`define NACS_OP_NOP        3'h0
`define NACS_OP_ADD_IMM    3'h1
`define NACS_OP_ADD_MEM    3'h2
`define NACS_OP_ADD_MEM_C  3'h3
`define NACS_OP_CONV_START 3'h4
`endif

/* hdl/nacs_pkg.sv */
`include "nacs_defs.svh"
package nacs_pkg;
	typedef enum logic [2:0] {
		NACS_NOP        = 3'h0,
		NACS_ADD_IMM    = 3'h1,
		NACS_ADD_MEM    = 3'h2,
		NACS_ADD_MEM_C  = 3'h3,
		NACS_CONV_START = 3'h4
	} nacs_op_t;

	typedef struct packed {
		logic       op_valid;
		nacs_op_t   op;
		logic [3:0] imm;
		logic [3:0] mem_data;
	} nacs_req_t;

	typedef struct packed {
		logic skip;
		logic conv_start;
		logic cmp_start;
		logic done_clear;
	} nacs_evt_t;
endpackage

/* hdl/nacs_datapath.sv */
`timescale 1ns/1ps
`include "nacs_defs.svh"
module nacs_datapath
	import nacs_pkg::*;
#(
	// Bit of the converter control register that selects compare mode.
	parameter int MODE_BIT = `NACS_MODE_BIT
)
(
	// Clock and reset.
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Decoded instruction with the nibble read at the data pointer.
	input  wire nacs_req_t  req_in,
	// Converter control register contents.
	input  wire logic [3:0] converter_control_reg_in,
	// Architectural state and sequencer events.
	output logic [3:0]      acc_out,
	output logic            carry_flag_out,
	output nacs_evt_t       evt_out
);
	// Every request is taken at the edge where it is presented.
	// Results and event pulses show one cycle later.
	// Refused requests leave all state alone and raise no event.

	// The nibble width is fixed by the request and port layout.
	localparam int DATA_W = `NACS_DATA_W;

	// Accumulator group.
	logic [DATA_W-1:0] acc_reg;
	logic [DATA_W-1:0] acc_next;

	// Carry group.
	logic              carry_reg;
	logic              carry_next;

	// Sequencer event group.
	nacs_evt_t         evt_reg;
	nacs_evt_t         evt_next;

	// Shared adder: one chain serves all three add instructions.
	logic [DATA_W-1:0] operand_b;
	logic              carry_in;
	logic [DATA_W:0]   ripple;
	logic [DATA_W-1:0] sum_bits;
	logic              carry_out;

	// One-hot decode of the instruction in this cycle.
	logic              dec_add_imm;
	logic              dec_add_mem;
	logic              dec_add_mem_c;
	logic              dec_conv_start;
	logic              dec_sum;

	// True when the request is valid and carries the given opcode.
	function automatic logic op_is(
		input nacs_req_t req,
		input nacs_op_t  code
	);
		return req.op_valid && (req.op == code);
	endfunction

	// Reads the mode select bit of the converter control register.
	function automatic logic compare_mode(
		input logic [3:0] ctrl
	);
		return ctrl[MODE_BIT];
	endfunction

	// Opcodes outside the table decode to nothing and change no state.
	always_comb begin
		dec_add_imm    = 1'b0;
		dec_add_mem    = 1'b0;
		dec_add_mem_c  = 1'b0;
		dec_conv_start = 1'b0;
		case (req_in.op)
			NACS_NOP: begin
				dec_add_imm = 1'b0;
			end
			NACS_ADD_IMM: begin
				dec_add_imm = op_is(req_in, NACS_ADD_IMM);
			end
			NACS_ADD_MEM: begin
				dec_add_mem = op_is(req_in, NACS_ADD_MEM);
			end
			NACS_ADD_MEM_C: begin
				dec_add_mem_c = op_is(req_in, NACS_ADD_MEM_C);
			end
			NACS_CONV_START: begin
				dec_conv_start = op_is(req_in, NACS_CONV_START);
			end
			default: begin
				dec_add_imm    = 1'b0;
				dec_add_mem    = 1'b0;
				dec_add_mem_c  = 1'b0;
				dec_conv_start = 1'b0;
			end
		endcase
		dec_sum = dec_add_imm | dec_add_mem | dec_add_mem_c;
	end

	// Immediate adds take the immediate field, the others the memory nibble.
	always_comb begin
		operand_b = req_in.mem_data;
		carry_in  = 1'b0;
		if (dec_add_imm) begin
			operand_b = req_in.imm;
		end
		if (dec_add_mem_c) begin
			carry_in = carry_reg;
		end
	end

	assign ripple[0] = carry_in;

	// A ripple chain is slow, but four bits settle well inside one cycle.
	generate
		for (genvar i = 0; i < DATA_W; i++) begin : g_bit
			nacs_full_add u_add (
				.a_in      (acc_reg[i]),
				.b_in      (operand_b[i]),
				.carry_in  (ripple[i]),
				.sum_out   (sum_bits[i]),
				.carry_out (ripple[i+1])
			);
		end
	endgenerate

	// Overflow is the carry out of the top bit of the nibble.
	assign carry_out = ripple[DATA_W];

	// Accumulator: every add writes the low four bits of the sum back.
	always_comb begin
		acc_next = acc_reg;
		if (dec_sum) begin
			acc_next = sum_bits;
		end
	end

	// Registers only; the next value is worked out above.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			acc_reg <= `NACS_ACC_RESET;
		end else begin
			acc_reg <= acc_next;
		end
	end

	// Only the carry form touches the flag; the other adds keep it.
	always_comb begin
		carry_next = carry_reg;
		if (dec_add_mem_c) begin
			carry_next = carry_out;
		end
	end

	// Registers only; the next value is worked out above.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			carry_reg <= `NACS_CARRY_RESET;
		end else begin
			carry_reg <= carry_next;
		end
	end

	// Events are one-cycle pulses; the sequencer and converter latch them.
	// Back-to-back starts give back-to-back pulses, with no merging.
	always_comb begin
		evt_next = '0;
		if (dec_add_imm) begin
			evt_next.skip = carry_out;
		end
		if (dec_conv_start) begin
			// The done flag lives outside; this pulse asks it to clear.
			evt_next.done_clear = 1'b1;
			evt_next.conv_start =
				~compare_mode(converter_control_reg_in);
			evt_next.cmp_start  =
				compare_mode(converter_control_reg_in);
		end
	end

	// Registers only; the next value is worked out above.
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			evt_reg.skip       <= 1'b0;
			evt_reg.conv_start <= 1'b0;
			evt_reg.cmp_start  <= 1'b0;
			evt_reg.done_clear <= 1'b0;
		end else begin
			evt_reg.skip       <= evt_next.skip;
			evt_reg.conv_start <= evt_next.conv_start;
			evt_reg.cmp_start  <= evt_next.cmp_start;
			evt_reg.done_clear <= evt_next.done_clear;
		end
	end

	assign acc_out        = acc_reg;
	assign carry_flag_out = carry_reg;
	assign evt_out        = evt_reg;
endmodule

// One bit of the accumulator adder.
// Kept as its own module so the carry chain is easy to follow.
module nacs_full_add (
	// Operand bits and incoming carry.
	input  wire logic a_in,
	input  wire logic b_in,
	input  wire logic carry_in,
	// Sum bit and outgoing carry.
	output logic      sum_out,
	output logic      carry_out
);
	logic half_sum;

	assign half_sum  = a_in ^ b_in;
	assign sum_out   = half_sum ^ carry_in;
	assign carry_out = (a_in & b_in) | (carry_in & half_sum);
endmodule

/* dv/nacs_datapath_props.sv */
`timescale 1ns/1ps
module nacs_props
	import nacs_pkg::*;
(
	// Clock and reset of the datapath.
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// Request and control inputs.
	input  wire nacs_req_t  req_in,
	input  wire logic [3:0] converter_control_reg_in,
	// Registered results.
	input  wire logic [3:0] acc_out,
	input  wire logic       carry_flag_out,
	input  wire nacs_evt_t  evt_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// Opcode with its valid bit on top, and sums built from the rules.
	wire logic [3:0] o  = {req_in.op_valid, req_in.op};
	wire logic [4:0] s  = {1'b0, acc_out} + {1'b0, req_in.mem_data}
		+ {4'h0, carry_flag_out};
	wire logic [4:0] si = {1'b0, acc_out} + {1'b0, req_in.imm};
	wire logic [4:0] sm = {1'b0, acc_out} + {1'b0, req_in.mem_data};

	chk_carry_add: assert property (o == 4'hB |=>
		{carry_flag_out, acc_out} == $past(s))
		else $error("carry add result wrong");
	chk_imm_sum: assert property (o == 4'h9 |=>
		acc_out == $past(si[3:0])
		&& carry_flag_out == $past(carry_flag_out))
		else $error("immediate add result wrong");
	chk_imm_skip: assert property (o == 4'h9 |=>
		evt_out.skip == $past(si[4]))
		else $error("immediate add skip wrong");
	chk_mem_sum: assert property (o == 4'hA |=>
		acc_out == $past(sm[3:0])
		&& carry_flag_out == $past(carry_flag_out) && !evt_out.skip)
		else $error("memory add result wrong");
	chk_conv_mode: assert property (o == 4'hC |=>
		evt_out == ($past(converter_control_reg_in[3]) ? 4'h3 : 4'h5))
		else $error("converter start events wrong");
	chk_idle_hold: assert property (!req_in.op_valid |=>
		$stable(acc_out) && $stable(carry_flag_out) && evt_out == 4'h0)
		else $error("idle cycle changed state");

	cov_imm_skip: cover property (o == 4'h9 ##1 evt_out.skip);
	cov_carry_out: cover property (o == 4'hB ##1 carry_flag_out);
	cov_compare: cover property (o == 4'hC ##1 evt_out.cmp_start);
	cov_convert: cover property (o == 4'hC ##1 evt_out.conv_start);
endmodule
bind nacs_datapath nacs_props p (.*);

/* dv/tb.sv */
`timescale 1ns/1ps
module tb import nacs_pkg::*;;
	logic clk_in = 0, rst_in = 1, c;
	logic [3:0] q = 4'h0, a, e;
	nacs_req_t r = '0;
	int num_errors, checks;
	logic [27:0] t [9] = '{28'h9F000F0, 28'hB010100, 28'hA0F01F0,
		28'h9100108, 28'hB020030, 28'hC007035, 28'hC008033,
		28'h1F00030, 28'h0};
	always #2.5 clk_in = ~clk_in;
	nacs_datapath dut (.clk_in, .rst_in, .req_in(r), .acc_out(a),
		.converter_control_reg_in(q), .carry_flag_out(c), .evt_out(e));
	task chk(logic [8:0] v, x);
		checks++;
		if (v !== x) begin
			num_errors++;
			$display("BAD %0t %h %h", $time, v, x);
		end
	endtask
	task finish_test;
		if (!num_errors && checks) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_in);
		rst_in <= 0;
		for (int i = 0; i < 9; i++) begin
			@(posedge clk_in) {r, q} <= t[i][27:12];
			#1 if (i) chk({c, a, e}, t[i-1][8:0]);
		end
		// Memory add that overflows: no skip, carry kept.
		@(posedge clk_in) r <= 12'hA0F;
		@(posedge clk_in) r <= '0;
		#1 chk({c, a, e}, 9'h020);
		@(posedge clk_in) begin
			r <= 12'hC00;
			q <= 4'h8;
		end
		@(posedge clk_in) r <= '0;
		#1 chk({c, a, e}, 9'h023);
		@(posedge clk_in) #1 chk({c, a, e}, 9'h020);
		// An opcode outside the table is refused.
		@(posedge clk_in) r <= 12'hDFF;
		@(posedge clk_in) r <= '0;
		#1 chk({c, a, e}, 9'h020);
		// Reset in mid-run, then a request right after release.
		@(posedge clk_in) begin
			rst_in <= 1'b1;
			r      <= 12'h9F0;
		end
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		#1 chk({c, a, e}, 9'h000);
		@(posedge clk_in) r <= '0;
		#1 chk({c, a, e}, 9'h0F0);
		finish_test;
	end
endmodule
